/* File: include/port1_pkg.sv */
// Package with register map, field positions and carrier types for the port 1 function selector
//
// Notes on behaviour
// RQ1 - Select register, eight bits, resets to zero
// RQ2 - Bit 7 picks interrupt three / timer F
// RQ3 - Bit 6 picks interrupt two / timer C
// RQ4 - Bit 5 picks interrupt one / timer B
// RQ5 - Bit 4 drives pin from PWM
// RQ6 - Bit 2 drives pin from timer F high compare
// RQ7 - Bit 1 drives pin from timer F low compare
// RQ8 - Bit 0 drives pin from clock divider
// RQ9 - Software writes zero to bit 3
// RQ10 - Reduced variant: software zeroes bits 6, 4, 3
// RQ11 - Event inputs offer rising or falling edge
// RQ12 - Pin 7 feeds timer F when clock select 0xx
// RQ13 - Timer F use: software disables interrupt three
// RQ14 - Pin 6 set by select, timer C mode, direction
// RQ15 - Direction one is output, zero is input
// RQ16 - Direction and latch only matter for general I/O
// RQ17 - Unimplemented select bits read zero, ignore writes
package port1_pkg;

    // Register byte addresses on APB
    localparam logic [7:0] SEL_OFFSET    = 8'h00; // Function select register
    localparam logic [7:0] DIR_OFFSET    = 8'h04; // Direction register
    localparam logic [7:0] LATCH_OFFSET  = 8'h08; // Output latch register
    localparam logic [7:0] EDGE_OFFSET   = 8'h0c; // Edge polarity register
    localparam logic [7:0] TCFG_OFFSET   = 8'h10; // Timer configuration register
    localparam logic [7:0] PIN_OFFSET    = 8'h14; // Pin state readback

    // Reset values
    localparam logic [7:0] SEL_RESET     = 8'h00;
    localparam logic [7:0] DIR_RESET     = 8'h00;
    localparam logic [7:0] LATCH_RESET   = 8'h00;
    localparam logic [2:0] EDGE_RESET    = 3'h0;
    localparam logic [5:0] TCFG_RESET    = 6'h00;

    // Writable bits of the select register, full and reduced variants
    localparam logic [7:0] SEL_MASK_FULL = 8'hf7;
    localparam logic [7:0] SEL_MASK_LITE = 8'ha7;

    // Select bit positions
    localparam int SEL_EXT_INT_THREE_SELECT  = 7;
    localparam int SEL_EXT_INT_TWO_SELECT  = 6;
    localparam int SEL_EXT_INT_ONE_SELECT  = 5;
    localparam int SEL_PWM   = 4;
    localparam int SEL_TFH   = 2;
    localparam int SEL_TFL   = 1;
    localparam int SEL_CLK   = 0;

    // Timer configuration fields
    localparam int TCFG_CKSL_LSB = 0; // Timer F clock select, 3 bits
    localparam int TCFG_TMC_LSB  = 3; // Timer C mode field, 3 bits
    localparam logic [2:0] TMC_EXT_EVENT = 3'h7; // Timer C counts pin events

    // Alternate function outputs from peripherals
    typedef struct packed {
        logic pwm_out;                  // Pulse-width modulator output
        logic timer_f_high_compare_out; // Timer F high byte compare
        logic timer_f_low_compare_out;  // Timer F low byte compare
        logic clock_divider_out;        // Clock output function
    } alt_out_t;

    // Event and interrupt requests toward peripherals
    typedef struct packed {
        logic ext_int_three_req; // Edge pulse, interrupt three
        logic ext_int_two_req;   // Edge pulse, interrupt two
        logic ext_int_one_req;   // Edge pulse, interrupt one
        logic timer_f_event_in;  // Edge pulse to timer F
        logic timer_c_event_in;  // Edge pulse to timer C
        logic timer_b_event_in;  // Edge pulse to timer B
    } event_out_t;

endpackage : port1_pkg

/* File: rtl/port1_pin_function_select.sv */
// Port 1 pin function selector with APB register file and pin routing
`timescale 1ns/1ps

module port1_pin_function_select #(
    parameter bit REDUCED = 1'b0                      // Reduced variant lacks bits 6 and 4
) (
    input  wire logic                 pclk,           // APB clock, 40 MHz
    input  wire logic                 presetn,        // Asynchronous reset, active low
    input  wire logic                 psel,           // APB select
    input  wire logic                 penable,        // APB access phase
    input  wire logic                 pwrite,         // APB write
    input  wire logic [7:0]           paddr,          // APB byte address
    input  wire logic [31:0]          pwdata,         // APB write data
    output logic      [31:0]          prdata,         // APB read data
    output logic                      pready,         // APB ready
    output logic                      pslverr,        // APB error on unmapped address
    input  wire port1_pkg::alt_out_t  alt_out,        // Peripheral outputs for the pins
    output port1_pkg::event_out_t     events,         // Edge pulses toward interrupts and timers
    input  wire logic [7:0]           pin_in,         // Pad input levels
    output logic      [7:0]           pin_out,        // Pad output values
    output logic      [7:0]           pin_oe_n        // Pad output enables, low drives
);
    import port1_pkg::*;

    // Registers
    logic [7:0] port1_function_select_r; // Function select
    logic [7:0] port1_direction_r;       // Direction per pin
    logic [7:0] port1_output_latch_r;    // Output latch per pin
    logic [2:0] edge_rise_r;             // Edge polarity for pins 7, 6, 5; 1 = rising
    logic [5:0] timer_cfg_r;             // Timer C mode and timer F clock select copies
    logic [7:0] pin_meta_r;              // First synchroniser stage
    logic [7:0] pin_sync_r;              // Second synchroniser stage
    logic [2:0] pin_prev_r;              // Previous synced level, pins 7..5
    logic [7:0] sel_mask;                // Writable select bits
    logic [7:0] rd_nxt;                  // Read mux
    logic       hit;                     // Address is mapped
    logic       wr_en;                   // Write strobe
    logic [2:0] edge_seen;               // Selected edges on pins 7..5
    logic [2:0] timer_f_clock_select;    // Timer F clock select field
    logic [2:0] timer_c_mode_field;      // Timer C mode field

    // Decode used by both read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == SEL_OFFSET) || (a == DIR_OFFSET) || (a == LATCH_OFFSET) ||
                 (a == EDGE_OFFSET) || (a == TCFG_OFFSET) || (a == PIN_OFFSET);
    endfunction : mapped

    // Single-cycle access phase; unmapped addresses flag an error
    assign sel_mask = REDUCED ? SEL_MASK_LITE : SEL_MASK_FULL; // [RQ17] [RQ10]
    assign hit      = mapped(paddr);
    assign wr_en    = psel && penable && pwrite && hit;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;
    assign timer_f_clock_select = timer_cfg_r[TCFG_CKSL_LSB +: 3];
    assign timer_c_mode_field   = timer_cfg_r[TCFG_TMC_LSB +: 3];

    // Function select register, unimplemented bits forced to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_function_select_r <= SEL_RESET; // [RQ1]
        end else if (wr_en && paddr == SEL_OFFSET) begin
            port1_function_select_r <= pwdata[7:0] & sel_mask; // [RQ1] [RQ9] [RQ17]
        end
    end

    // Direction and output latch registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_direction_r    <= DIR_RESET;
            port1_output_latch_r <= LATCH_RESET;
        end else if (wr_en) begin
            if (paddr == DIR_OFFSET) begin
                port1_direction_r <= pwdata[7:0];
            end
            if (paddr == LATCH_OFFSET) begin
                port1_output_latch_r <= pwdata[7:0];
            end
        end
    end

    // Edge polarity and timer configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_rise_r <= EDGE_RESET;
            timer_cfg_r <= TCFG_RESET;
        end else if (wr_en) begin
            if (paddr == EDGE_OFFSET) begin
                edge_rise_r <= pwdata[2:0]; // [RQ11]
            end
            if (paddr == TCFG_OFFSET) begin
                timer_cfg_r <= pwdata[5:0];
            end
        end
    end

    // Read mux, upper bits zero
    always_comb begin
        rd_nxt = 8'h00;
        unique case (paddr)
            SEL_OFFSET:   rd_nxt = port1_function_select_r; // [RQ17]
            DIR_OFFSET:   rd_nxt = port1_direction_r;
            LATCH_OFFSET: rd_nxt = port1_output_latch_r;
            EDGE_OFFSET:  rd_nxt = {5'h00, edge_rise_r};
            TCFG_OFFSET:  rd_nxt = {2'h0, timer_cfg_r};
            PIN_OFFSET:   rd_nxt = pin_sync_r;
            default:      rd_nxt = 8'h00;
        endcase
    end

    // Read data registered from setup phase so it is valid in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_nxt};
        end
    end

    // Two-stage pin synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
            pin_prev_r <= 3'h0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r[7:5];
        end
    end

    // Rising or falling edge detection on the event pins
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            assign edge_seen[g] = edge_rise_r[g] ? (pin_sync_r[g+5] && !pin_prev_r[g])   // [RQ11]
                                                 : (!pin_sync_r[g+5] && pin_prev_r[g]);
        end
    endgenerate

    // Event pulses, registered; gated by the select bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
        end else begin
            events.ext_int_three_req <= port1_function_select_r[SEL_EXT_INT_THREE_SELECT] && edge_seen[2]; // [RQ2] [RQ12]
            events.timer_f_event_in  <= port1_function_select_r[SEL_EXT_INT_THREE_SELECT] && edge_seen[2]
                                        && !timer_f_clock_select[2]; // [RQ12]
            events.ext_int_two_req   <= port1_function_select_r[SEL_EXT_INT_TWO_SELECT] && edge_seen[1]; // [RQ3]
            events.timer_c_event_in  <= port1_function_select_r[SEL_EXT_INT_TWO_SELECT] && edge_seen[1]
                                        && timer_c_mode_field == TMC_EXT_EVENT; // [RQ14]
            events.ext_int_one_req   <= port1_function_select_r[SEL_EXT_INT_ONE_SELECT] && edge_seen[0]; // [RQ4]
            events.timer_b_event_in  <= port1_function_select_r[SEL_EXT_INT_ONE_SELECT] && edge_seen[0]; // [RQ4]
        end
    end

    // Pad drive: alternate function owns a selected pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out  <= 8'h00;
            pin_oe_n <= 8'hff;
        end else begin
            // General I/O defaults from latch and direction
            pin_out  <= port1_output_latch_r;                    // [RQ16]
            pin_oe_n <= ~port1_direction_r;                      // [RQ15]
            // Event inputs never drive
            if (port1_function_select_r[SEL_EXT_INT_THREE_SELECT]) begin
                pin_oe_n[7] <= 1'b1;                             // [RQ2] [RQ16]
            end
            if (port1_function_select_r[SEL_EXT_INT_TWO_SELECT]) begin
                pin_oe_n[6] <= 1'b1;                             // [RQ3] [RQ14]
            end
            if (port1_function_select_r[SEL_EXT_INT_ONE_SELECT]) begin
                pin_oe_n[5] <= 1'b1;                             // [RQ4]
            end
            // Output alternates
            if (port1_function_select_r[SEL_PWM]) begin
                pin_out[4]  <= alt_out.pwm_out;                  // [RQ5]
                pin_oe_n[4] <= 1'b0;
            end
            if (port1_function_select_r[SEL_TFH]) begin
                pin_out[2]  <= alt_out.timer_f_high_compare_out; // [RQ6]
                pin_oe_n[2] <= 1'b0;
            end
            if (port1_function_select_r[SEL_TFL]) begin
                pin_out[1]  <= alt_out.timer_f_low_compare_out;  // [RQ7]
                pin_oe_n[1] <= 1'b0;
            end
            if (port1_function_select_r[SEL_CLK]) begin
                pin_out[0]  <= alt_out.clock_divider_out;        // [RQ8]
                pin_oe_n[0] <= 1'b0;
            end
        end
    end

endmodule : port1_pin_function_select

/* File: bench/port1_pin_function_select_asserts.sv */
// Port-level assertions for the port 1 function selector
`timescale 1ns/1ps
module port1_pin_function_select_asserts
    import port1_pkg::*;
#(
    parameter bit REDUCED = 1'b0                 // Variant flag
) (
    input wire logic                 pclk,       // Clock
    input wire logic                 presetn,    // Reset, active low
    input wire logic                 psel,       // Select
    input wire logic                 penable,    // Access phase
    input wire logic                 pwrite,     // Write
    input wire logic [7:0]           paddr,      // Address
    input wire logic [31:0]          pwdata,     // Write data
    input wire logic [31:0]          prdata,     // Read data
    input wire logic                 pready,     // Ready
    input wire logic                 pslverr,    // Error
    input wire port1_pkg::alt_out_t  alt_out,    // Peripheral outputs
    input wire port1_pkg::event_out_t events,    // Event pulses
    input wire logic [7:0]           pin_in,     // Pad inputs
    input wire logic [7:0]           pin_out,    // Pad outputs
    input wire logic [7:0]           pin_oe_n    // Pad enables
);
    logic [7:0] sel_r;                            // Shadow of the select register
    logic [7:0] dir_r;                            // Shadow of the direction register
    logic [7:0] latch_r;                          // Shadow of the output latch
    wire        wr_w   = psel && penable && pwrite && pready; // Write completes
    wire        map_w  = paddr inside {SEL_OFFSET, DIR_OFFSET, LATCH_OFFSET, EDGE_OFFSET, TCFG_OFFSET, PIN_OFFSET};

    // Track software writes so pin checks know the routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r   <= 8'h00;
            dir_r   <= 8'h00;
            latch_r <= 8'h00;
        end else if (wr_w) begin
            if (paddr == SEL_OFFSET) sel_r <= pwdata[7:0] & (REDUCED ? SEL_MASK_LITE : SEL_MASK_FULL);
            if (paddr == DIR_OFFSET) dir_r <= pwdata[7:0];
            if (paddr == LATCH_OFFSET) latch_r <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_tied_a: assert property (pready) else $error("ready low");
    slverr_map_a: assert property (psel && penable |-> pslverr == !map_w) else $error("bad error flag");
    rdata_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
    clk_route_a: assert property ($past(sel_r[0]) |-> pin_out[0] == $past(alt_out.clock_divider_out)
        && !pin_oe_n[0]) else $error("pin 0 not clock output");
    pwm_route_a: assert property ($past(sel_r[4]) |-> pin_out[4] == $past(alt_out.pwm_out)
        && !pin_oe_n[4]) else $error("pin 4 not pwm output");
    gpio_pin_a: assert property (!$past(sel_r[2]) |-> pin_out[2] == $past(latch_r[2])
        && pin_oe_n[2] == !$past(dir_r[2])) else $error("pin 2 not general io");
    irq_input_a: assert property ($past(sel_r[7]) |-> pin_oe_n[7]) else $error("pin 7 driven");
    event_gate_a: assert property ((!sel_r[5])[*6] |=> !events.ext_int_one_req && !events.timer_b_event_in)
        else $error("event while unselected");
    event_pulse_a: assert property (events.ext_int_three_req |=> !events.ext_int_three_req)
        else $error("event longer than one cycle");
endmodule : port1_pin_function_select_asserts

bind port1_pin_function_select port1_pin_function_select_asserts #(.REDUCED(REDUCED)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alt_out(alt_out),
    .events(events), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* File: bench/port1_pin_function_select_test.sv */
// Self-checking bench for the port 1 function selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module port1_pin_function_select_test;
    import port1_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus control
    logic [7:0]  paddr = 8'h00, pin_in = 8'h00, pin_out, pin_oe_n; // Address and pads
    logic [31:0] pwdata = 32'h0, prdata;          // Bus data
    logic        pready, pslverr;                 // Bus answer
    alt_out_t    alt_out = '0;                    // Peripheral outputs
    event_out_t  events;                          // Event pulses
    int          bad_count = 0, checks_done = 0, cyc = 0; // Counters
    logic [31:0] prdata_lite;                     // Read data of the reduced variant

    always #12.5 pclk = ~pclk;

    port1_pin_function_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alt_out(alt_out), .events(events), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    // Reduced variant on the same bus; only its read data is watched
    port1_pin_function_select #(.REDUCED(1'b1)) dut_lite (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_lite), .pready(),
        .pslverr(), .alt_out(alt_out), .events(), .pin_in(pin_in), .pin_out(), .pin_oe_n());

    // One bus transfer: setup, then access until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x; logic er;
        apb(1'b1, a, d, x, er);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] x; logic er;
        apb(1'b0, a, 32'h0, x, er);
        `CHK("prdata", e, x)
        `CHK("pslverr", ee, er)
    endtask : rd

    // Alternate output b driven from peripheral line a
    task route(input int b, input int a);
        wr(SEL_OFFSET, 32'h1 << b);
        alt_out <= 4'(1 << a);
        repeat (3) @(posedge pclk);
        `CHK("pin_out", 1'b1, pin_out[b])
        `CHK("pin_oe_n", 1'b0, pin_oe_n[b])
        alt_out <= ~4'(1 << a);
        repeat (3) @(posedge pclk);
        `CHK("pin_out", 1'b0, pin_out[b])
    endtask : route

    // Move one pad and gather every event pulse that follows
    task ev(input int p, input logic lv, input logic [5:0] ex);
        logic [5:0] acc;
        acc = 6'h00;
        pin_in[p] <= lv;
        repeat (8) begin @(posedge pclk); acc = acc | events; end
        `CHK("events", ex, acc)
    endtask : ev

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin bad_count++; tally_and_finish; end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("pin_oe_n", 8'hff, pin_oe_n)
        rd(SEL_OFFSET, 32'h0, 1'b0);
        wr(SEL_OFFSET, 32'hffffffff);
        rd(SEL_OFFSET, {24'h0, SEL_MASK_FULL}, 1'b0);
        `CHK("prdata_lite", 32'h0000_00a7, prdata_lite)
        wr(8'h18, 32'h5a);
        rd(8'h18, 32'h0, 1'b1);
        $display("test registers done");
        route(0, 0);
        route(1, 1);
        route(2, 2);
        route(4, 3);
        $display("test alternate outputs done");
        wr(DIR_OFFSET, 32'hff);
        wr(LATCH_OFFSET, 32'ha5);
        wr(SEL_OFFSET, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK("pin_out", 8'ha5, pin_out)
        `CHK("pin_oe_n", 8'h00, pin_oe_n)
        wr(SEL_OFFSET, 32'he0);
        repeat (3) @(posedge pclk);
        `CHK("pin_oe_n", 3'h7, pin_oe_n[7:5])
        wr(DIR_OFFSET, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK("pin_oe_n", 8'hff, pin_oe_n)
        $display("test general io done");
        wr(EDGE_OFFSET, 32'h7);
        wr(TCFG_OFFSET, 32'h38);
        ev(7, 1'b1, 6'h24);
        ev(7, 1'b0, 6'h00);
        ev(6, 1'b1, 6'h12);
        ev(5, 1'b1, 6'h09);
        wr(EDGE_OFFSET, 32'h0);
        wr(TCFG_OFFSET, 32'h04);
        ev(6, 1'b0, 6'h10);
        ev(5, 1'b0, 6'h09);
        ev(7, 1'b1, 6'h00);
        ev(7, 1'b0, 6'h20);
        wr(SEL_OFFSET, 32'h0);
        ev(5, 1'b1, 6'h00);
        ev(5, 1'b0, 6'h00);
        pin_in <= 8'h3c;
        repeat (4) @(posedge pclk);
        rd(PIN_OFFSET, 32'h3c, 1'b0);
        $display("test events done");
        tally_and_finish;
    end
endmodule : port1_pin_function_select_test
